// [sbc_map.svh]
// Purpose: Named constants for the sleep, time-tag and barometric command block.
// Assumes: 100 MHz system clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_CLK_MHZ 100
`define SBC_WAKE_MS 600
`define SBC_WAKE_CYC (`SBC_WAKE_MS * 1000 * `SBC_CLK_MHZ)
`define SBC_SEC_CYC (1000000 * `SBC_CLK_MHZ)
`define SBC_US_CYC `SBC_CLK_MHZ
`define SBC_HOUR_SEC 3600
`define SBC_TMO_MIN 8'h05
`define SBC_TMO_MAX 8'hFF
`define SBC_TMO_DEF 8'h0A
`define SBC_TEND_NEED 3'h4
`define SBC_PAD_DIGITS 4'h9
`define SBC_DA_ROUND_FT 16'h0064
`define SBC_PA_ROUND_FT 16'h000A
`define SBC_MODE_CONT_P 3'h1
`define SBC_MODE_DISP 3'h2
`endif

// [sbc_pkg.sv]
// Purpose: Types shared by the command block files.
// Assumes: Nothing beyond the constant header.
// Notes: Command codes and reply kinds.
package sbc_pkg;
  typedef enum logic [3:0] {
    SBC_CMD_NONE = 4'h0,
    SBC_CMD_PRESS = 4'h1,
    SBC_CMD_PERIOD = 4'h2,
    SBC_CMD_FIELD = 4'h3,
    SBC_CMD_STATION = 4'h4,
    SBC_CMD_SEALVL = 4'h5,
    SBC_CMD_ALTSET = 4'h6,
    SBC_CMD_DENSALT = 4'h7,
    SBC_CMD_PRESALT = 4'h8,
    SBC_CMD_TEND = 4'h9
  } sbc_cmd_t;
  typedef enum logic [1:0] {
    SBC_STAMP_NONE = 2'h0,
    SBC_STAMP_VALUE = 2'h1,
    SBC_STAMP_ERR = 2'h2
  } sbc_stamp_t;
endpackage : sbc_pkg

// [sbc_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Asynchronous active-low reset.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module sbc_sync (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sbc_sync

// [sbc_tend_mem.sv]
// Purpose: Four-entry store of the most recent hourly pressure samples.
// Assumes: One write per hour at most.
// Notes: Read data come out of registers; entry 0 is the newest sample.
`timescale 1ns/1ps
module sbc_tend_mem (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic [31:0] data_in,
  output logic [31:0] newest_out,
  output logic [31:0] oldest_out
);
  logic [31:0] ent_reg [0:3];
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ent
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ent_reg[i] <= 32'h0000_0000;
        end else if (wr_in) begin
          ent_reg[i] <= (i == 0) ? data_in : ent_reg[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      newest_out <= 32'h0000_0000;
      oldest_out <= 32'h0000_0000;
    end else begin
      newest_out <= ent_reg[0];
      oldest_out <= ent_reg[3];
    end
  end
endmodule : sbc_tend_mem

// [sbc_top.sv]
// Purpose: Sleep control, reply time tag and barometric command dispatch.
// Assumes: Arithmetic, integration and serial framing live outside this block.
// Notes: All settings arrive as plain ports; outputs come from flip-flops.
//
// Summary of operation
// - Asleep, wake 0.6 s after any character on either serial port.
// - The waking character is dropped and never forwarded as command data.
// - Doze enable 0 disables sleep, 1 enables it; default 0.
// - With doze on, sleep after idle timeout seconds without any character.
// - Idle timeout is integer seconds 5 to 255, default 10.
// - Continuous pressure or display mode, or background fetch, inhibit sleep.
// - Time tag enable 1 appends microsecond stamp to pressure and period replies.
// - Stamp is interval from integration midpoint to first reply character start.
// - Fixed-width padding makes the stamp exactly nine digits.
// - With background fetch on, the error token replaces the stamp.
// - Field, station, sea-level, altimeter commands measure fresh, reply in pressure unit.
// - Density altitude reply rounds to 100 feet, unit by its selection.
// - Pressure altitude reply rounds to 10 feet, unit by its selection.
// - Sea-level computation takes station and sensor elevation plus reduction term.
// - Tendency code is computed only while background fetch is enabled.
// - Sample at power-up then hourly; code from four newest hourly samples.
// - Recompute the tendency code at every new hourly sample.
// - Tendency request before four samples answers with not-ready.
// - Nonzero reduction constant is used, otherwise the reduction ratio.
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_top #(
  parameter int unsigned WAKE_CYC = `SBC_WAKE_CYC,
  parameter int unsigned SEC_CYC = `SBC_SEC_CYC,
  parameter int unsigned HOUR_SEC = `SBC_HOUR_SEC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic rx_char_a_in,
  input wire logic rx_char_b_in,
  input wire logic [7:0] rx_data_in,
  input wire logic doze_enable_in,
  input wire logic [7:0] doze_idle_timeout_in,
  input wire logic [2:0] output_mode_select_in,
  input wire logic background_fetch_enable_in,
  input wire logic reply_time_tag_enable_in,
  input wire logic fixed_width_padding_in,
  input wire logic density_altitude_unit_in,
  input wire logic pressure_altitude_unit_in,
  input wire logic [31:0] reduction_constant_in,
  input wire logic cmd_valid_in,
  input wire sbc_pkg::sbc_cmd_t cmd_in,
  input wire logic integ_mid_in,
  input wire logic first_char_start_in,
  input wire logic meas_done_in,
  input wire logic [31:0] meas_pressure_in,
  output logic asleep_out,
  output logic rx_char_valid_out,
  output logic [7:0] rx_char_out,
  output logic meas_start_out,
  output sbc_pkg::sbc_cmd_t calc_cmd_out,
  output logic calc_use_constant_out,
  output logic [15:0] calc_round_ft_out,
  output logic calc_unit_meters_out,
  output sbc_pkg::sbc_stamp_t stamp_kind_out,
  output logic [31:0] stamp_us_out,
  output logic [3:0] stamp_digits_out,
  output logic tend_valid_out,
  output logic tend_not_ready_out,
  output logic tend_update_out,
  output logic [31:0] tend_delta_out
);
  import sbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic rx_a_sync;
  logic rx_b_sync;
  logic rx_a_dly_reg;
  logic rx_b_dly_reg;
  logic rx_evt;

  sbc_sync u_sync_a (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .async_in(rx_char_a_in),
    .sync_out(rx_a_sync)
  );
  sbc_sync u_sync_b (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .async_in(rx_char_b_in),
    .sync_out(rx_b_sync)
  );

  // Each character strobe is a level toggle-free pulse; detect its rising edge.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_a_dly_reg <= 1'b0;
      rx_b_dly_reg <= 1'b0;
    end else begin
      rx_a_dly_reg <= rx_a_sync;
      rx_b_dly_reg <= rx_b_sync;
    end
  end
  assign rx_evt = (rx_a_sync & ~rx_a_dly_reg) | (rx_b_sync & ~rx_b_dly_reg);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    SBC_PWR_AWAKE = 3'b001,
    SBC_PWR_SLEEP = 3'b010,
    SBC_PWR_WAKING = 3'b100
  } sbc_pwr_t;

  sbc_pwr_t pwr_reg;
  logic [31:0] sec_cnt_reg;
  logic [7:0] idle_sec_reg;
  logic [31:0] wake_cnt_reg;
  logic [7:0] tmo_eff;
  logic inhibit;

  // Out-of-range timeout settings fall back to the default.
  always_comb begin
    if (doze_idle_timeout_in < `SBC_TMO_MIN) begin
      tmo_eff = `SBC_TMO_DEF;
    end else begin
      tmo_eff = doze_idle_timeout_in;
    end
  end

  assign inhibit = (output_mode_select_in == `SBC_MODE_CONT_P) ||
                   (output_mode_select_in == `SBC_MODE_DISP) ||
                   background_fetch_enable_in;

  // Idle seconds counter, restarted by any character on either port.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sec_cnt_reg <= 32'h0000_0000;
      idle_sec_reg <= 8'h00;
    end else if (rx_evt || pwr_reg != SBC_PWR_AWAKE) begin
      sec_cnt_reg <= 32'h0000_0000;
      idle_sec_reg <= 8'h00;
    end else if (sec_cnt_reg == SEC_CYC - 1) begin
      sec_cnt_reg <= 32'h0000_0000;
      if (idle_sec_reg != `SBC_TMO_MAX) begin
        idle_sec_reg <= idle_sec_reg + 8'h01;
      end
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwr_reg <= SBC_PWR_AWAKE;
      wake_cnt_reg <= 32'h0000_0000;
    end else begin
      unique case (pwr_reg)
        SBC_PWR_AWAKE: begin
          if (doze_enable_in && !inhibit && !rx_evt && idle_sec_reg >= tmo_eff) begin
            pwr_reg <= SBC_PWR_SLEEP;
          end
        end
        SBC_PWR_SLEEP: begin
          if (rx_evt) begin
            pwr_reg <= SBC_PWR_WAKING;
            wake_cnt_reg <= 32'h0000_0000;
          end
        end
        SBC_PWR_WAKING: begin
          if (wake_cnt_reg == WAKE_CYC - 1) begin
            pwr_reg <= SBC_PWR_AWAKE;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Characters pass on only while awake; the waking one is swallowed.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      asleep_out <= 1'b0;
      rx_char_valid_out <= 1'b0;
      rx_char_out <= 8'h00;
    end else begin
      asleep_out <= (pwr_reg != SBC_PWR_AWAKE);
      rx_char_valid_out <= rx_evt && (pwr_reg == SBC_PWR_AWAKE);
      if (rx_evt) begin
        rx_char_out <= rx_data_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0] us_div_reg;
  logic [31:0] us_cnt_reg;
  logic [31:0] mid_us_reg;
  logic stamp_cmd_reg;

  // Free-running microsecond counter.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      us_div_reg <= 7'h00;
      us_cnt_reg <= 32'h0000_0000;
    end else if (us_div_reg == 7'(`SBC_US_CYC - 1)) begin
      us_div_reg <= 7'h00;
      us_cnt_reg <= us_cnt_reg + 32'h0000_0001;
    end else begin
      us_div_reg <= us_div_reg + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mid_us_reg <= 32'h0000_0000;
      stamp_cmd_reg <= 1'b0;
    end else begin
      if (integ_mid_in) begin
        mid_us_reg <= us_cnt_reg;
      end
      if (cmd_valid_in) begin
        stamp_cmd_reg <= (cmd_in == SBC_CMD_PRESS) || (cmd_in == SBC_CMD_PERIOD);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stamp_kind_out <= SBC_STAMP_NONE;
      stamp_us_out <= 32'h0000_0000;
      stamp_digits_out <= 4'h0;
    end else if (first_char_start_in) begin
      stamp_us_out <= us_cnt_reg - mid_us_reg;
      stamp_digits_out <= fixed_width_padding_in ? `SBC_PAD_DIGITS : 4'h0;
      if (!reply_time_tag_enable_in || !stamp_cmd_reg) begin
        stamp_kind_out <= SBC_STAMP_NONE;
      end else if (background_fetch_enable_in) begin
        stamp_kind_out <= SBC_STAMP_ERR;
      end else begin
        stamp_kind_out <= SBC_STAMP_VALUE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command dispatch to the external arithmetic.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meas_start_out <= 1'b0;
      calc_cmd_out <= SBC_CMD_NONE;
      calc_use_constant_out <= 1'b0;
      calc_round_ft_out <= 16'h0000;
      calc_unit_meters_out <= 1'b0;
    end else begin
      meas_start_out <= 1'b0;
      if (cmd_valid_in && cmd_in != SBC_CMD_TEND && cmd_in != SBC_CMD_NONE) begin
        meas_start_out <= 1'b1;
        calc_cmd_out <= cmd_in;
        calc_use_constant_out <= (reduction_constant_in != 32'h0000_0000);
        unique case (cmd_in)
          SBC_CMD_DENSALT: begin
            calc_round_ft_out <= `SBC_DA_ROUND_FT;
            calc_unit_meters_out <= density_altitude_unit_in;
          end
          SBC_CMD_PRESALT: begin
            calc_round_ft_out <= `SBC_PA_ROUND_FT;
            calc_unit_meters_out <= pressure_altitude_unit_in;
          end
          default: begin
            calc_round_ft_out <= 16'h0000;
            calc_unit_meters_out <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] hr_cyc_reg;
  logic [11:0] hr_sec_reg;
  logic take_sample_reg;
  logic fetch_on_reg;
  logic [2:0] samples_reg;
  logic calc_pend_reg;
  logic calc_pend2_reg;
  logic [31:0] newest;
  logic [31:0] oldest;

  // Hourly sample clock runs always; first sample at power-up; samples are stored only while fetch runs.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hr_cyc_reg <= 32'h0000_0000;
      hr_sec_reg <= 12'h000;
      take_sample_reg <= 1'b1;
    end else begin
      if (meas_done_in && take_sample_reg && background_fetch_enable_in) begin
        take_sample_reg <= 1'b0;
      end
      if (hr_cyc_reg == SEC_CYC - 1) begin
        hr_cyc_reg <= 32'h0000_0000;
        if (hr_sec_reg == 12'(HOUR_SEC - 1)) begin
          hr_sec_reg <= 12'h000;
          take_sample_reg <= 1'b1;
        end else begin
          hr_sec_reg <= hr_sec_reg + 12'h001;
        end
      end else begin
        hr_cyc_reg <= hr_cyc_reg + 32'h0000_0001;
      end
    end
  end

  logic sample_wr;
  assign sample_wr = meas_done_in && take_sample_reg && background_fetch_enable_in;

  sbc_tend_mem u_mem (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_in(sample_wr),
    .data_in(meas_pressure_in),
    .newest_out(newest),
    .oldest_out(oldest)
  );

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      samples_reg <= 3'h0;
      calc_pend_reg <= 1'b0;
      calc_pend2_reg <= 1'b0;
      fetch_on_reg <= 1'b0;
      tend_valid_out <= 1'b0;
      tend_update_out <= 1'b0;
      tend_delta_out <= 32'h0000_0000;
    end else begin
      fetch_on_reg <= background_fetch_enable_in;
      tend_update_out <= 1'b0;
      if (sample_wr && samples_reg != `SBC_TEND_NEED) begin
        samples_reg <= samples_reg + 3'h1;
      end
      // Memory read registers lag the write by two edges.
      calc_pend_reg <= sample_wr;
      calc_pend2_reg <= calc_pend_reg;
      if (calc_pend2_reg && samples_reg == `SBC_TEND_NEED && fetch_on_reg) begin
        tend_delta_out <= newest - oldest;
        tend_valid_out <= 1'b1;
        tend_update_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tend_not_ready_out <= 1'b0;
    end else begin
      tend_not_ready_out <= cmd_valid_in && (cmd_in == SBC_CMD_TEND) &&
                            !tend_valid_out;
    end
  end
endmodule : sbc_top

// [sbc_checker.sv]
// Purpose: Port-level assertions for the sleep, stamp and command block.
// Assumes: Bound to sbc_top from the bench top file.
// Notes: One clock domain, so default clocking and disable are used.
`timescale 1ns/1ps
module sbc_checker (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic doze_enable_in,
  input wire logic [2:0] output_mode_select_in,
  input wire logic background_fetch_enable_in,
  input wire logic reply_time_tag_enable_in,
  input wire logic fixed_width_padding_in,
  input wire logic density_altitude_unit_in,
  input wire logic [31:0] reduction_constant_in,
  input wire logic cmd_valid_in,
  input wire sbc_pkg::sbc_cmd_t cmd_in,
  input wire logic first_char_start_in,
  input wire logic asleep_out,
  input wire logic rx_char_valid_out,
  input wire logic meas_start_out,
  input wire sbc_pkg::sbc_cmd_t calc_cmd_out,
  input wire logic calc_use_constant_out,
  input wire logic [15:0] calc_round_ft_out,
  input wire logic calc_unit_meters_out,
  input wire sbc_pkg::sbc_stamp_t stamp_kind_out,
  input wire logic [3:0] stamp_digits_out,
  input wire logic tend_valid_out,
  input wire logic tend_not_ready_out
);
  import sbc_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic stamp_cmd_seen;
  // Remembers whether the last accepted command is one that carries a stamp.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stamp_cmd_seen <= 1'b0;
    end else if (cmd_valid_in) begin
      stamp_cmd_seen <= (cmd_in == SBC_CMD_PRESS) || (cmd_in == SBC_CMD_PERIOD);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_wake_char_drop: assert property (
    rx_char_valid_out |-> !$past(asleep_out)) else $error("char forwarded while asleep");
  chk_sleep_allowed: assert property (
    $rose(asleep_out) |-> $past(doze_enable_in) && !$past(background_fetch_enable_in)
      && $past(output_mode_select_in) != 3'h1 && $past(output_mode_select_in) != 3'h2)
    else $error("sleep entered while inhibited");
  chk_asleep_hold: assert property (
    $rose(asleep_out) |=> asleep_out [*8]) else $error("sleep ended too soon");
  chk_meas_start: assert property (
    cmd_valid_in && !(cmd_in inside {SBC_CMD_NONE, SBC_CMD_TEND})
      |=> meas_start_out && calc_cmd_out == $past(cmd_in)) else $error("no measure start");
  chk_tend_not_ready: assert property (
    cmd_valid_in && cmd_in == SBC_CMD_TEND && !tend_valid_out |=> tend_not_ready_out)
    else $error("missing not-ready answer");
  chk_dens_round: assert property (
    meas_start_out && calc_cmd_out == SBC_CMD_DENSALT |-> calc_round_ft_out == 16'h0064
      && calc_unit_meters_out == $past(density_altitude_unit_in)) else $error("density rounding");
  chk_reduction_pick: assert property (
    meas_start_out && calc_cmd_out == SBC_CMD_SEALVL
      |-> calc_use_constant_out == ($past(reduction_constant_in) != 32'h0000_0000))
    else $error("reduction term choice");
  chk_stamp_error: assert property (
    first_char_start_in && background_fetch_enable_in && reply_time_tag_enable_in
      && stamp_cmd_seen |=> stamp_kind_out == SBC_STAMP_ERR)
    else $error("stamp not error under fetch");
  chk_stamp_pad: assert property (
    first_char_start_in && reply_time_tag_enable_in && fixed_width_padding_in
      ##1 stamp_kind_out == SBC_STAMP_VALUE |-> stamp_digits_out == 4'h9)
    else $error("stamp not padded");
  chk_tend_fetch: assert property (
    $rose(tend_valid_out) |-> $past(background_fetch_enable_in, 2))
    else $error("tendency without fetch");
endmodule : sbc_checker

// [sbc_host_model.sv]
// Purpose: Serial host that strobes characters into either port.
// Assumes: Strobe high three cycles per character.
// Notes: Data keeps the character one cycle after the strobe drops, then shows its complement.
`timescale 1ns/1ps
module sbc_host_model #(
  parameter int unsigned WAKE_CYC = 20
) (
  input wire logic sys_clk_in,
  output logic rx_char_a_out,
  output logic rx_char_b_out,
  output logic [7:0] rx_data_out
);
  initial begin
    rx_char_a_out = 1'b0;
    rx_char_b_out = 1'b0;
    rx_data_out = 8'h00;
  end
  task automatic send_char(input logic port_b, input logic [7:0] ch);
    @(posedge sys_clk_in);
    rx_char_a_out <= !port_b;
    rx_char_b_out <= port_b;
    rx_data_out <= ch;
    repeat (3) @(posedge sys_clk_in);
    rx_char_a_out <= 1'b0;
    rx_char_b_out <= 1'b0;
    @(posedge sys_clk_in);
    rx_data_out <= ~ch;
    @(posedge sys_clk_in);
  endtask : send_char
  task automatic wake_then_send(input logic port_b, input logic [7:0] ch);
    send_char(port_b, 8'h7E);
    repeat (WAKE_CYC + 4) @(posedge sys_clk_in);
    send_char(port_b, ch);
  endtask : wake_then_send
endmodule : sbc_host_model

// [sbc_tb_top.sv]
// Purpose: Self-checking bench for sbc_top.
// Assumes: Shortened second, hour and wake counts.
// Notes: Inputs change by non-blocking assignment, strobes at the rising edge and most settings 1 ns after it.
`timescale 1ns/1ps
module sbc_tb_top;
  import sbc_pkg::*;
  localparam int unsigned WAKE = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic doze = 1'b0;
  logic [7:0] tmo = 8'h0A;
  logic [2:0] mode = 3'h0;
  logic fetch = 1'b0, tag = 1'b0, pad = 1'b0, dunit = 1'b0, punit = 1'b0;
  logic cv = 1'b0, mid = 1'b0, fcs = 1'b0, mdone = 1'b0, feed = 1'b0;
  logic [31:0] rconst = 32'h0000_0000;
  logic [31:0] mpress = 32'h0000_0000;
  sbc_cmd_t cmd = SBC_CMD_NONE;
  logic ca, cb, asleep, rxv, mst, cuse, cunit, tvalid, tnr, tupd;
  logic [7:0] cd, rxd;
  sbc_cmd_t ccmd;
  logic [15:0] cround;
  sbc_stamp_t skind;
  logic [31:0] sus, tdelta;
  logic [3:0] sdig;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  sbc_top #(.WAKE_CYC(WAKE), .SEC_CYC(10), .HOUR_SEC(3)) uut (.sys_clk_in(clk),
    .rstn_in(rstn), .rx_char_a_in(ca), .rx_char_b_in(cb), .rx_data_in(cd),
    .doze_enable_in(doze), .doze_idle_timeout_in(tmo), .output_mode_select_in(mode),
    .background_fetch_enable_in(fetch), .reply_time_tag_enable_in(tag),
    .fixed_width_padding_in(pad), .density_altitude_unit_in(dunit),
    .pressure_altitude_unit_in(punit), .reduction_constant_in(rconst), .cmd_valid_in(cv),
    .cmd_in(cmd), .integ_mid_in(mid), .first_char_start_in(fcs), .meas_done_in(mdone),
    .meas_pressure_in(mpress), .asleep_out(asleep), .rx_char_valid_out(rxv),
    .rx_char_out(rxd), .meas_start_out(mst), .calc_cmd_out(ccmd),
    .calc_use_constant_out(cuse), .calc_round_ft_out(cround), .calc_unit_meters_out(cunit),
    .stamp_kind_out(skind), .stamp_us_out(sus), .stamp_digits_out(sdig),
    .tend_valid_out(tvalid), .tend_not_ready_out(tnr), .tend_update_out(tupd),
    .tend_delta_out(tdelta));
  sbc_host_model #(.WAKE_CYC(WAKE)) host (.sys_clk_in(clk), .rx_char_a_out(ca),
    .rx_char_b_out(cb), .rx_data_out(cd));
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    mdone <= feed & ~mdone;
    mpress <= mpress + 32'h0000_0001;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic mon(input int n, output int na, output int nv, output logic [7:0] d);
    na = 0;
    nv = 0;
    d = 8'h00;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (asleep === 1'b1) na++;
      if (rxv === 1'b1) begin
        nv++;
        d = rxd;
      end
    end
  endtask : mon
  task automatic cmd_go(input sbc_cmd_t c);
    @(posedge clk);
    cv <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask : cmd_go
  task automatic t_sleep(input logic [7:0] t, input int exp);
    int n, nv;
    logic [7:0] d;
    tmo <= t;
    doze <= 1'b1;
    host.send_char(1'b1, 8'h20);
    n = 0;
    while (asleep !== 1'b1 && n < exp + 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n >= exp - 8 && n <= exp + 4, 1, "sleep entry time");
    fork
      host.wake_then_send(1'b0, 8'h31);
      mon(WAKE * 3, n, nv, d);
    join
    check(n >= WAKE && n <= WAKE + 6, 1, "wake delay");
    check(nv, 1, "only command char forwarded");
    check(d, 8'h31, "command char data");
  endtask : t_sleep
  task automatic t_inhibit();
    int na, nv;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      doze <= (i != 3);
      mode <= (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h0;
      fetch <= (i == 2);
      tmo <= 8'h05;
      host.send_char(i[0], 8'h41);
      mon(120, na, nv, d);
      check(na, 0, "sleep not inhibited");
    end
    doze <= 1'b0;
    mode <= 3'h0;
    fetch <= 1'b0;
  endtask : t_inhibit
  task automatic t_cmds();
    sbc_cmd_t c;
    dunit <= 1'b1;
    punit <= 1'b0;
    for (int i = 1; i < 10; i++) begin
      c = (i == 9) ? SBC_CMD_SEALVL : sbc_cmd_t'(i);
      rconst <= (i == 5) ? 32'h0000_1234 : 32'h0000_0000;
      cmd_go(c);
      check(mst, 1, "measure start");
      check(ccmd, c, "calc command");
      check(cround, (c == SBC_CMD_DENSALT) ? 16'h0064 :
        (c == SBC_CMD_PRESALT) ? 16'h000A : 16'h0000, "rounding");
      if (c inside {SBC_CMD_DENSALT, SBC_CMD_PRESALT}) check(cunit, c == SBC_CMD_DENSALT, "unit");
      if (c == SBC_CMD_SEALVL) check(cuse, i == 5, "reduction constant use");
    end
  endtask : t_cmds
  task automatic t_stamp(input sbc_cmd_t c, input logic tg, pd, fe, input sbc_stamp_t k,
    input logic [3:0] dg);
    tag <= tg;
    pad <= pd;
    fetch <= fe;
    cmd_go(c);
    @(posedge clk);
    mid <= 1'b1;
    @(posedge clk);
    mid <= 1'b0;
    repeat (499) @(posedge clk);
    fcs <= 1'b1;
    @(posedge clk);
    fcs <= 1'b0;
    #1;
    check(skind, k, "stamp kind");
    if (k == SBC_STAMP_VALUE) begin
      check(sus, 32'h0000_0005, "stamp microseconds");
      check(sdig, dg, "stamp digits");
    end
  endtask : t_stamp
  task automatic t_tend();
    int n;
    feed <= 1'b1;
    repeat (40) @(posedge clk);
    cmd_go(SBC_CMD_TEND);
    check(tnr, 1, "not ready without fetch");
    rstn <= 1'b0;
    fetch <= 1'b1;
    repeat (3) @(posedge clk);
    check(asleep, 0, "awake in reset");
    rstn <= 1'b1;
    cmd_go(SBC_CMD_TEND);
    check(tnr, 1, "not ready early");
    n = 0;
    while (tvalid !== 1'b1 && n < 150) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n >= 82 && n <= 96, 1, "fourth hourly sample");
    check(tdelta >= 32'h0000_0057 && tdelta <= 32'h0000_005C, 1, "newest minus oldest");
    n = 0;
    repeat (32) begin
      @(posedge clk);
      #1;
      if (tupd === 1'b1) n++;
    end
    check(n, 1, "hourly recompute");
    cmd_go(SBC_CMD_TEND);
    check(tnr, 0, "code ready");
    feed <= 1'b0;
  endtask : t_tend
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check(asleep, 0, "awake after reset");
    t_sleep(8'h05, 50);
    t_sleep(8'h04, 100);
    t_sleep(8'hFF, 2550);
    t_inhibit();
    t_cmds();
    t_stamp(SBC_CMD_PRESS, 1'b1, 1'b1, 1'b0, SBC_STAMP_VALUE, 4'h9);
    t_stamp(SBC_CMD_PERIOD, 1'b1, 1'b0, 1'b0, SBC_STAMP_VALUE, 4'h0);
    t_stamp(SBC_CMD_FIELD, 1'b1, 1'b1, 1'b0, SBC_STAMP_NONE, 4'h0);
    t_stamp(SBC_CMD_PRESS, 1'b1, 1'b1, 1'b1, SBC_STAMP_ERR, 4'h0);
    t_stamp(SBC_CMD_PRESS, 1'b0, 1'b1, 1'b0, SBC_STAMP_NONE, 4'h0);
    t_tend();
    wrap_up();
  end
endmodule : sbc_tb_top
bind sbc_top sbc_checker u_chk (.*);
